// ===== hw/psm_defs.svh
// object indices, field positions, words and reset values of the power state machine
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_IDX_CTL 16'h6040
`define PSM_IDX_STAT 16'h6041
`define PSM_IDX_MODE 16'h6060
`define PSM_IDX_MODE_SHOWN 16'h6061
`define PSM_IDX_QS_OPT 16'h605a
`define PSM_IDX_HOLD 16'h3212
`define PSM_SUB_HOLD 8'h01
`define PSM_IDX_SUBMODE 16'h3202
`define PSM_IDX_STEP_MUL 16'h2057
`define PSM_IDX_STEP_DIV 16'h2058
`define PSM_CW_FR_BIT 7
`define PSM_SW_INDEX_BIT 15
`define PSM_SUBMODE_CL_BIT 0
`define PSM_MODE_CLKDIR 8'hff
`define PSM_MODE_RST 8'h00
`define PSM_QS_OPT_RST 16'h0002
`define PSM_STEP_MUL_RST 32'h00000001
`define PSM_STEP_DIV_RST 32'h00000001
`define PSM_CW_SHUTDOWN 16'h0006
`define PSM_CW_SWITCH_ON 16'h0007
`define PSM_CW_ENABLE_OP 16'h000f
`define PSM_CW_DISABLE_OP 16'h0007
`define PSM_CW_DIS_VOLT 16'h0000
`define PSM_CW_QSTOP 16'h0002
`define PSM_CW_FR_HIGH 16'h0080
`define PSM_SW_NOT_READY 16'h0000
`define PSM_SW_SW_DIS 16'h0040
`define PSM_SW_READY 16'h0021
`define PSM_SW_SW_ON 16'h0023
`define PSM_SW_OP_EN 16'h0027
`define PSM_SW_QSTOP 16'h0007
`define PSM_SW_FLT_REACT 16'h000f
`define PSM_SW_FAULT 16'h0008
`endif

// ===== hw/psm_device.sv
// drive end: control word decoder, power state machine and status word
`timescale 1ns/100ps
`include "psm_defs.svh"
// Operation
// - commands via control word, state via status
// - shutdown, switch on, enable operation decoding
// - disable voltage, quick stop, disable operation
// - fault reset only on bit 7 rise
// - status patterns for first four states
// - status patterns for remaining four states
// - self-test done enters switch on disabled
// - mode takes effect at operation enabled
// - mode writes only in three idle states
// - unrecoverable error locks not ready state
// - holding torque only when option is one
// - master sets submode bit before closed loop
// - status bit 15 after encoder index seen, while enc_commut is high
// - master refuses closed loop until auto setup done
// - clock-direction steps scaled by multiplier, divider
// - quick stop reaction per programmed option
module psm_device #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  psm_if.dev link,
  input wire logic selftest_ok,
  input wire logic unrecov_err,
  input wire logic recov_fault,
  input wire logic fault_react_done,
  input wire logic ramp_done,
  input wire logic enc_commut,
  input wire logic enc_index_pin,
  input wire logic step_pin,
  output psm_pkg::psm_state_t state,
  output logic power_on,
  output logic drive_on,
  output logic hold_torque,
  output psm_pkg::psm_ramp_t stop_ramp,
  output logic closed_loop,
  output logic [7:0] mode_active,
  output logic step_out
);
  import psm_pkg::*;

  typedef struct packed {
    psm_state_t st;
    logic locked;
    logic [15:0] ctl;
    logic fr_prev;
    logic [7:0] mode_req;
    logic [7:0] mode_act;
    logic [15:0] qs_opt;
    logic hold_opt;
    logic cl_sel;
    logic [W-1:0] mul;
    logic [W-1:0] div;
    logic [W:0] acc;
    logic step_prev;
    logic idx_seen;
    logic step_out;
    logic [15:0] status;
    logic power_on;
    logic drive_on;
    logic hold_torque;
    psm_ramp_t ramp;
  } psm_dev_t;

  psm_dev_t s;
  psm_dev_t next_s;
  logic idx_sync;
  logic step_sync;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  psm_sync3 u_sync_idx (
    .clk(clk),
    .rst_n(rst_n),
    .d(enc_index_pin),
    .q(idx_sync)
  );
  psm_sync3 u_sync_step (
    .clk(clk),
    .rst_n(rst_n),
    .d(step_pin),
    .q(step_sync)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic c7;
  logic cmd_dv;
  logic cmd_qs;
  logic cmd_sd;
  logic cmd_so;
  logic cmd_eo;
  logic fr_rise;
  logic mode_ok;
  logic [W:0] sum;

  always_comb begin
    next_s = s;
    next_s.step_out = 1'b0;
    c7 = s.ctl[`PSM_CW_FR_BIT];
    // commands only count with bit 7 low; x bits are not looked at
    cmd_dv = !c7 && !s.ctl[1];
    cmd_qs = !c7 && s.ctl[2:1] == 2'b01;
    cmd_sd = !c7 && s.ctl[2:0] == 3'b110;
    cmd_so = !c7 && s.ctl[3:0] == 4'b0111;
    cmd_eo = !c7 && s.ctl[3:0] == 4'b1111;
    fr_rise = c7 && !s.fr_prev;
    next_s.fr_prev = c7;
    mode_ok = s.st == ST_SW_DIS || s.st == ST_READY || s.st == ST_SW_ON;
    sum = '0;

    // object writes from the master
    if (link.obj_wr) begin
      case (link.obj_idx)
        `PSM_IDX_CTL: begin
          next_s.ctl = link.obj_data[15:0];
        end
        `PSM_IDX_MODE: begin
          if (mode_ok) begin
            next_s.mode_req = link.obj_data[7:0];
          end
        end
        `PSM_IDX_QS_OPT: begin
          next_s.qs_opt = link.obj_data[15:0];
        end
        `PSM_IDX_HOLD: begin
          if (link.obj_sub == `PSM_SUB_HOLD) begin
            next_s.hold_opt = link.obj_data == 32'h00000001;
          end
        end
        `PSM_IDX_SUBMODE: begin
          next_s.cl_sel = link.obj_data[`PSM_SUBMODE_CL_BIT];
        end
        `PSM_IDX_STEP_MUL: begin
          next_s.mul = link.obj_data[W-1:0];
        end
        `PSM_IDX_STEP_DIV: begin
          next_s.div = link.obj_data[W-1:0];
        end
        default: begin
        end
      endcase
    end

    // power state machine
    if (unrecov_err || s.locked) begin
      next_s.locked = 1'b1;
      next_s.st = ST_NOT_READY;
    end else if (recov_fault && s.st inside {ST_READY, ST_SW_ON, ST_OP_EN, ST_QSTOP}) begin
      next_s.st = ST_FLT_REACT;
    end else begin
      case (s.st)
        ST_NOT_READY: begin
          if (selftest_ok) begin
            next_s.st = ST_SW_DIS;
          end
        end
        ST_SW_DIS: begin
          if (cmd_sd) begin
            next_s.st = ST_READY;
          end
        end
        ST_READY: begin
          if (cmd_dv || cmd_qs) begin
            next_s.st = ST_SW_DIS;
          end else if (cmd_so) begin
            next_s.st = ST_SW_ON;
          end
        end
        ST_SW_ON: begin
          if (cmd_dv || cmd_qs) begin
            next_s.st = ST_SW_DIS;
          end else if (cmd_sd) begin
            next_s.st = ST_READY;
          end else if (cmd_eo) begin
            next_s.st = ST_OP_EN;
            next_s.mode_act = s.mode_req;
          end
        end
        ST_OP_EN: begin
          if (cmd_dv) begin
            next_s.st = ST_SW_DIS;
          end else if (cmd_qs) begin
            next_s.st = ST_QSTOP;
          end else if (cmd_sd) begin
            next_s.st = ST_READY;
          end else if (cmd_so) begin
            next_s.st = ST_SW_ON;
          end
        end
        ST_QSTOP: begin
          if (cmd_dv) begin
            next_s.st = ST_SW_DIS;
          end else if (s.ramp != RAMP_NONE && ramp_done) begin
            next_s.st = ST_SW_DIS;
          end
        end
        ST_FLT_REACT: begin
          if (fault_react_done) begin
            next_s.st = ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (fr_rise) begin
            next_s.st = ST_SW_DIS;
          end
        end
        default: begin
          next_s.st = ST_NOT_READY;
        end
      endcase
    end

    // quick stop reaction, latched on entry
    if (next_s.st == ST_QSTOP && s.st != ST_QSTOP) begin
      case (s.qs_opt)
        16'h0001: next_s.ramp = RAMP_SLOW;
        16'h0002: next_s.ramp = RAMP_QUICK;
        default: next_s.ramp = RAMP_NONE;
      endcase
    end else if (next_s.st != ST_QSTOP) begin
      next_s.ramp = RAMP_NONE;
    end

    // clock-direction step scaling
    next_s.step_prev = step_sync;
    if (s.st == ST_OP_EN && s.mode_act == `PSM_MODE_CLKDIR && step_sync && !s.step_prev) begin
      sum = s.acc + {1'b0, s.mul};
      if (s.div != '0 && sum >= {1'b0, s.div}) begin
        next_s.acc = sum - {1'b0, s.div};
        next_s.step_out = 1'b1;
      end else begin
        next_s.acc = sum;
      end
    end

    if (idx_sync) begin
      next_s.idx_seen = 1'b1;
    end

    // outputs follow the new state in the same cycle
    case (next_s.st)
      ST_SW_DIS: next_s.status = `PSM_SW_SW_DIS;
      ST_READY: next_s.status = `PSM_SW_READY;
      ST_SW_ON: next_s.status = `PSM_SW_SW_ON;
      ST_OP_EN: next_s.status = `PSM_SW_OP_EN;
      ST_QSTOP: next_s.status = `PSM_SW_QSTOP;
      ST_FLT_REACT: next_s.status = `PSM_SW_FLT_REACT;
      ST_FAULT: next_s.status = `PSM_SW_FAULT;
      default: next_s.status = `PSM_SW_NOT_READY;
    endcase
    next_s.status[`PSM_SW_INDEX_BIT] = enc_commut && next_s.idx_seen;
    next_s.power_on = next_s.st inside {ST_SW_ON, ST_OP_EN, ST_QSTOP};
    next_s.drive_on = next_s.st == ST_OP_EN || (next_s.st == ST_QSTOP && next_s.ramp != RAMP_NONE);
    next_s.hold_torque = next_s.st == ST_SW_ON && next_s.hold_opt;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= ST_NOT_READY;
      s.mode_req <= `PSM_MODE_RST;
      s.mode_act <= `PSM_MODE_RST;
      s.qs_opt <= `PSM_QS_OPT_RST;
      s.mul <= W'(`PSM_STEP_MUL_RST);
      s.div <= W'(`PSM_STEP_DIV_RST);
      s.ramp <= RAMP_NONE;
      s.status <= `PSM_SW_NOT_READY;
    end else begin
      s <= next_s;
    end
  end

  assign link.status_word = s.status;
  assign link.mode_shown = s.mode_act;
  assign state = s.st;
  assign power_on = s.power_on;
  assign drive_on = s.drive_on;
  assign hold_torque = s.hold_torque;
  assign stop_ramp = s.ramp;
  assign closed_loop = s.cl_sel;
  assign mode_active = s.mode_act;
  assign step_out = s.step_out;
endmodule : psm_device

// ===== hw/psm_host.sv
// master end: turns user commands into object writes on the link
`timescale 1ns/100ps
`include "psm_defs.svh"
module psm_host (
  input wire logic clk,
  input wire logic rst_n,
  psm_if.host link,
  input wire logic cmd_valid,
  input psm_pkg::psm_cmd_t cmd,
  input wire logic mode_valid,
  input wire logic [7:0] mode,
  input wire logic cfg_valid,
  input wire logic [15:0] cfg_idx,
  input wire logic [7:0] cfg_sub,
  input wire logic [31:0] cfg_data,
  input wire logic autosetup_done,
  output logic ready,
  output logic refused,
  output logic [15:0] status_word,
  output logic [7:0] mode_shown
);
  import psm_pkg::*;

  typedef struct packed {
    psm_host_st_t st;
    logic [15:0] ctl;
    logic wr;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] data;
    logic refused;
    logic [15:0] status;
    logic [7:0] mode_shown;
  } psm_host_t;

  psm_host_t s;
  psm_host_t next_s;
  logic op_en;

  // ----------------------------------------------------------------
  // request handling
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.refused = 1'b0;
    next_s.status = link.status_word;
    next_s.mode_shown = link.mode_shown;
    op_en = s.status[6:5] == 2'b01 && s.status[3:0] == 4'b0111;
    case (s.st)
      HS_IDLE: begin
        if (cmd_valid) begin
          next_s.wr = 1'b1;
          next_s.idx = `PSM_IDX_CTL;
          next_s.sub = 8'h00;
          case (cmd)
            CMD_SHUTDOWN: next_s.ctl = `PSM_CW_SHUTDOWN;
            CMD_SWITCH_ON: next_s.ctl = `PSM_CW_SWITCH_ON;
            CMD_ENABLE_OP: next_s.ctl = `PSM_CW_ENABLE_OP;
            CMD_DISABLE_OP: next_s.ctl = `PSM_CW_DISABLE_OP;
            CMD_DIS_VOLT: next_s.ctl = `PSM_CW_DIS_VOLT;
            CMD_QSTOP: next_s.ctl = `PSM_CW_QSTOP;
            CMD_FAULT_RESET: begin
              // low first, so the following write is a true rising edge
              next_s.ctl = s.ctl & ~`PSM_CW_FR_HIGH;
              next_s.st = HS_RISE;
            end
            default: begin
              next_s.idx = `PSM_IDX_SUBMODE;
              if (autosetup_done) begin
                next_s.data = 32'h00000001;
              end else begin
                next_s.wr = 1'b0;
                next_s.refused = 1'b1;
              end
            end
          endcase
          if (cmd != CMD_CLOSED_LOOP) begin
            next_s.data = {16'h0000, next_s.ctl};
          end
        end else if (mode_valid) begin
          if (op_en) begin
            next_s.refused = 1'b1;
          end else begin
            next_s.wr = 1'b1;
            next_s.idx = `PSM_IDX_MODE;
            next_s.sub = 8'h00;
            next_s.data = {24'h000000, mode};
          end
        end else if (cfg_valid) begin
          next_s.wr = 1'b1;
          next_s.idx = cfg_idx;
          next_s.sub = cfg_sub;
          next_s.data = cfg_data;
        end
      end
      HS_RISE: begin
        next_s.wr = 1'b1;
        next_s.ctl = s.ctl | `PSM_CW_FR_HIGH;
        next_s.data = {16'h0000, next_s.ctl};
        next_s.st = HS_IDLE;
      end
      default: begin
        next_s.st = HS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= HS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign ready = s.st == HS_IDLE;
  assign refused = s.refused;
  assign status_word = s.status;
  assign mode_shown = s.mode_shown;
  assign link.obj_wr = s.wr;
  assign link.obj_idx = s.idx;
  assign link.obj_sub = s.sub;
  assign link.obj_data = s.data;
endmodule : psm_host

// ===== hw/psm_if.sv
// object link between fieldbus master and drive
`timescale 1ns/100ps
interface psm_if;
  logic obj_wr;
  logic [15:0] obj_idx;
  logic [7:0] obj_sub;
  logic [31:0] obj_data;
  logic [15:0] status_word;
  logic [7:0] mode_shown;
  modport dev(input obj_wr, obj_idx, obj_sub, obj_data, output status_word, mode_shown);
  modport host(output obj_wr, obj_idx, obj_sub, obj_data, input status_word, mode_shown);
endinterface : psm_if

// ===== hw/psm_pkg.sv
// types shared by both ends of the power state machine link
package psm_pkg;
  typedef enum logic [2:0] {
    ST_NOT_READY, ST_SW_DIS, ST_READY, ST_SW_ON,
    ST_OP_EN, ST_QSTOP, ST_FLT_REACT, ST_FAULT
  } psm_state_t;
  typedef enum logic [1:0] {RAMP_NONE, RAMP_SLOW, RAMP_QUICK} psm_ramp_t;
  typedef enum logic [2:0] {
    CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_ENABLE_OP, CMD_DISABLE_OP,
    CMD_DIS_VOLT, CMD_QSTOP, CMD_FAULT_RESET, CMD_CLOSED_LOOP
  } psm_cmd_t;
  typedef enum logic {HS_IDLE, HS_RISE} psm_host_st_t;
endpackage : psm_pkg

// ===== hw/psm_sync3.sv
// three-stage pin synchroniser, output changes once stages two and three agree
`timescale 1ns/100ps
module psm_sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic [2:0] r;
    logic q;
  } psm_sync_t;
  psm_sync_t s;
  psm_sync_t next_s;
  always_comb begin
    next_s = s;
    next_s.r = {s.r[1:0], d};
    if (s.r[1] == s.r[2]) begin
      next_s.q = s.r[2];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign q = s.q;
endmodule : psm_sync3

// ===== verification/psm_link_chk.sv
// assertions on the object link between master and drive
`timescale 1ns/100ps
`include "psm_defs.svh"
module psm_link_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic obj_wr,
  input wire logic [15:0] obj_idx,
  input wire logic [7:0] obj_sub,
  input wire logic [31:0] obj_data,
  input wire logic [15:0] status_word,
  input wire logic [7:0] mode_shown
);
  logic cw;
  logic [15:0] s;
  logic [3:0] fr_age;
  assign cw = obj_wr && obj_idx == `PSM_IDX_CTL && !obj_data[7];
  assign s = {1'b0, status_word[14:0]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // cycles since a control word write with bit 7 set
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fr_age <= 4'hf;
    end else if (obj_wr && obj_idx == `PSM_IDX_CTL && obj_data[7]) begin
      fr_age <= 4'h0;
    end else if (fr_age != 4'hf) begin
      fr_age <= fr_age + 4'h1;
    end
  end
  a_status_legal: assert property ((s & 16'h7f10) == 16'h0 && s inside {`PSM_SW_NOT_READY, `PSM_SW_SW_DIS,
    `PSM_SW_READY, `PSM_SW_SW_ON, `PSM_SW_OP_EN, `PSM_SW_QSTOP, `PSM_SW_FLT_REACT, `PSM_SW_FAULT})
    else $error("status word pattern illegal");
  a_shutdown_ready: assert property (cw && obj_data[2:0] == 3'h6 && s == `PSM_SW_SW_DIS
    |-> ##[1:3] s == `PSM_SW_READY) else $error("shutdown did not reach ready");
  a_enable_op: assert property (cw && obj_data[3:0] == 4'hf && s == `PSM_SW_SW_ON
    |-> ##[1:3] s == `PSM_SW_OP_EN) else $error("enable did not reach operation");
  a_disable_op: assert property (cw && obj_data[3:0] == 4'h7 && s == `PSM_SW_OP_EN
    |-> ##[1:3] s == `PSM_SW_SW_ON) else $error("disable operation failed");
  a_quick_stop: assert property (cw && obj_data[2:1] == 2'b01 && s == `PSM_SW_OP_EN
    |-> ##[1:3] s == `PSM_SW_QSTOP) else $error("quick stop not entered");
  a_volt_off: assert property (cw && !obj_data[1] && s inside {`PSM_SW_READY, `PSM_SW_SW_ON, `PSM_SW_OP_EN}
    |-> ##[1:3] s == `PSM_SW_SW_DIS) else $error("disable voltage failed");
  a_fault_exit: assert property ($past(s) == `PSM_SW_FAULT && s == `PSM_SW_SW_DIS |-> fr_age <= 4'h3)
    else $error("fault left without bit 7 rise");
  a_fr_pair: assert property (obj_wr && obj_idx == `PSM_IDX_CTL && obj_data[7] |-> $past(cw))
    else $error("bit 7 set without preceding clear write");
  a_mode_take: assert property ($changed(mode_shown) |-> s == `PSM_SW_OP_EN)
    else $error("mode changed outside operation enabled");
  a_mode_hold: assert property (s == `PSM_SW_OP_EN && $past(s) == `PSM_SW_OP_EN |-> $stable(mode_shown))
    else $error("mode changed in operation enabled");
endmodule : psm_link_chk

// ===== verification/tb.sv
// self-checking bench: master and drive joined over the object link
`timescale 1ns/100ps
`include "psm_defs.svh"
module tb;
  import psm_pkg::*;
  logic clk, rst_n, cmd_valid, mode_valid, cfg_valid, autosetup_done, got_ref, refused;
  logic selftest_ok, unrecov_err, recov_fault, fault_react_done, ramp_done, enc_commut, enc_index_pin;
  logic hold_torque, closed_loop, step_pin, power_on, drive_on, ready, step_out;
  psm_cmd_t cmd;
  psm_ramp_t stop_ramp;
  psm_state_t state;
  logic [7:0] mode, cfg_sub, mode_shown, mode_active;
  logic [15:0] cfg_idx, status_word;
  logic [31:0] cfg_data;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int step_cnt = 0;
  psm_if link();
  psm_device i_psm_device (.clk(clk), .rst_n(rst_n), .link(link.dev), .selftest_ok(selftest_ok),
    .unrecov_err(unrecov_err), .recov_fault(recov_fault), .fault_react_done(fault_react_done),
    .ramp_done(ramp_done), .enc_commut(enc_commut), .enc_index_pin(enc_index_pin), .step_pin(step_pin),
    .state(state), .power_on(power_on), .drive_on(drive_on), .hold_torque(hold_torque), .stop_ramp(stop_ramp),
    .closed_loop(closed_loop), .mode_active(mode_active), .step_out(step_out));
  psm_host i_psm_host (.clk(clk), .rst_n(rst_n), .link(link.host), .cmd_valid(cmd_valid), .cmd(cmd),
    .mode_valid(mode_valid), .mode(mode), .cfg_valid(cfg_valid), .cfg_idx(cfg_idx), .cfg_sub(cfg_sub),
    .cfg_data(cfg_data), .autosetup_done(autosetup_done), .ready(ready), .refused(refused),
    .status_word(status_word), .mode_shown(mode_shown));
  psm_link_chk i_psm_link_chk (.clk(clk), .rst_n(rst_n), .obj_wr(link.obj_wr), .obj_idx(link.obj_idx),
    .obj_sub(link.obj_sub), .obj_data(link.obj_data), .status_word(link.status_word),
    .mode_shown(link.mode_shown));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task settle();
    got_ref = 1'b0;
    repeat (7) begin
      @(posedge clk);
      if (refused === 1'b1) got_ref = 1'b1;
    end
  endtask : settle
  task send(input psm_cmd_t c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    settle();
  endtask : send
  task put_mode(input logic [7:0] m);
    @(posedge clk);
    mode_valid <= 1'b1;
    mode <= m;
    @(posedge clk);
    mode_valid <= 1'b0;
    settle();
  endtask : put_mode
  task put_cfg(input logic [15:0] i, input logic [7:0] b, input logic [31:0] d);
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_idx <= i;
    cfg_sub <= b;
    cfg_data <= d;
    @(posedge clk);
    cfg_valid <= 1'b0;
    settle();
  endtask : put_cfg
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_power_up();
    repeat (3) @(posedge clk);
    chk("status before self test", `PSM_SW_NOT_READY, status_word);
    chk("host ready", 16'h1, {15'h0, ready});
    selftest_ok <= 1'b1;
    settle();
    chk("status after self test", `PSM_SW_SW_DIS, status_word);
    $display("test power_up done");
  endtask : t_power_up
  task t_walk();
    put_mode(8'h03);
    send(CMD_SHUTDOWN);
    chk("ready status", `PSM_SW_READY, status_word);
    send(CMD_SWITCH_ON);
    chk("switched on status", `PSM_SW_SW_ON, status_word);
    chk("hold torque default", 16'h0, {15'h0, hold_torque});
    chk("mode before enable", 16'h0, {8'h0, mode_shown});
    put_cfg(`PSM_IDX_HOLD, `PSM_SUB_HOLD, 32'h1);
    chk("hold torque set", 16'h1, {15'h0, hold_torque});
    send(CMD_ENABLE_OP);
    chk("operation enabled status", `PSM_SW_OP_EN, status_word);
    chk("mode in force", 16'h3, {8'h0, mode_shown});
    put_mode(8'h01);
    chk("mode write refused", 16'h1, {15'h0, got_ref});
    send(CMD_DISABLE_OP);
    chk("disable operation status", `PSM_SW_SW_ON, status_word);
    chk("mode kept", 16'h3, {8'h0, mode_shown});
    send(CMD_DIS_VOLT);
    chk("disable voltage status", `PSM_SW_SW_DIS, status_word);
    $display("test walk done");
  endtask : t_walk
  task t_qstop();
    send(CMD_SHUTDOWN);
    send(CMD_SWITCH_ON);
    send(CMD_ENABLE_OP);
    send(CMD_QSTOP);
    chk("quick stop status", `PSM_SW_QSTOP, status_word);
    chk("quick stop ramp", {14'h0, RAMP_QUICK}, {14'h0, stop_ramp});
    ramp_done <= 1'b1;
    @(posedge clk);
    ramp_done <= 1'b0;
    settle();
    chk("after ramp status", `PSM_SW_SW_DIS, status_word);
    $display("test qstop done");
  endtask : t_qstop
  task t_fault();
    send(CMD_SHUTDOWN);
    recov_fault <= 1'b1;
    @(posedge clk);
    recov_fault <= 1'b0;
    settle();
    chk("fault reaction status", `PSM_SW_FLT_REACT, status_word);
    fault_react_done <= 1'b1;
    @(posedge clk);
    fault_react_done <= 1'b0;
    settle();
    chk("fault status", `PSM_SW_FAULT, status_word);
    send(CMD_SHUTDOWN);
    chk("fault holds", `PSM_SW_FAULT, status_word);
    send(CMD_FAULT_RESET);
    chk("fault reset status", `PSM_SW_SW_DIS, status_word);
    $display("test fault done");
  endtask : t_fault
  task t_closed_index();
    send(CMD_CLOSED_LOOP);
    chk("closed loop refused", 16'h2, {14'h0, got_ref, closed_loop});
    autosetup_done <= 1'b1;
    send(CMD_CLOSED_LOOP);
    chk("closed loop set", 16'h1, {14'h0, got_ref, closed_loop});
    enc_commut <= 1'b1;
    settle();
    chk("index not yet seen", 16'h0, {15'h0, status_word[15]});
    enc_index_pin <= 1'b1;
    repeat (3) @(posedge clk);
    enc_index_pin <= 1'b0;
    settle();
    chk("index seen", 16'h1, {15'h0, status_word[15]});
    enc_commut <= 1'b0;
    $display("test closed_index done");
  endtask : t_closed_index
  task t_step();
    int n;
    put_mode(`PSM_MODE_CLKDIR);
    put_cfg(`PSM_IDX_STEP_DIV, 8'h00, 32'h2);
    put_cfg(`PSM_IDX_QS_OPT, 8'h00, 32'h0);
    send(CMD_SHUTDOWN);
    send(CMD_SWITCH_ON);
    send(CMD_ENABLE_OP);
    chk("mode active", {8'h0, `PSM_MODE_CLKDIR}, {8'h0, mode_active});
    chk("state enabled", {13'h0, ST_OP_EN}, {13'h0, state});
    chk("power and drive on", 16'h3, {14'h0, power_on, drive_on});
    n = step_cnt;
    repeat (4) begin
      step_pin <= 1'b1;
      repeat (4) @(posedge clk);
      step_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    settle();
    chk("scaled steps", 16'h2, 16'(step_cnt - n));
    send(CMD_QSTOP);
    chk("immediate stop", 16'h0, {13'h0, stop_ramp, drive_on});
    ramp_done <= 1'b1;
    @(posedge clk);
    ramp_done <= 1'b0;
    settle();
    chk("immediate stop holds", `PSM_SW_QSTOP, status_word);
    send(CMD_DIS_VOLT);
    chk("stop left by voltage off", `PSM_SW_SW_DIS, status_word);
    $display("test step done");
  endtask : t_step
  task t_unrecov();
    unrecov_err <= 1'b1;
    @(posedge clk);
    unrecov_err <= 1'b0;
    settle();
    chk("locked status", `PSM_SW_NOT_READY, status_word);
    send(CMD_SHUTDOWN);
    chk("locked after command", `PSM_SW_NOT_READY, status_word);
    $display("test unrecov done");
  endtask : t_unrecov
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (step_out === 1'b1) begin
      step_cnt++;
    end
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    {rst_n, cmd_valid, mode_valid, cfg_valid, autosetup_done, selftest_ok} = 6'h0;
    {unrecov_err, recov_fault, fault_react_done, ramp_done, enc_commut, enc_index_pin, step_pin} = 7'h0;
    cmd = CMD_SHUTDOWN;
    mode = 8'h0;
    cfg_idx = 16'h0;
    cfg_sub = 8'h0;
    cfg_data = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up();
    t_walk();
    t_qstop();
    t_fault();
    t_closed_index();
    t_step();
    t_unrecov();
    end_sim();
  end
endmodule : tb
